// ==== src/egress_queue_sched_select.sv ====
`timescale 1ns/1ps
`default_nettype none
module egress_queue_sched_select (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output var egress_queue_sched_pkg::sched_mode_e egress_queue_mode [3],
   output logic [3:0][6:0] egress_queue_weight [3]
);
   //////////////////////////////////////////////////////////////////////////
   // decode helpers
   // the twelve split registers sit on consecutive indices, four per
   // port, highest queue first; a range test and a subtraction are
   // enough to find port and queue, so no table of addresses is kept

   // address lands on one of the twelve split registers
   function automatic logic split_hit(input logic [7:0] idx);
      split_hit = (idx >= `IDX_PORT1_QUEUE3_SPLIT) && (idx <= `IDX_PORT3_QUEUE0_SPLIT);
   endfunction

   // position among the split registers: [3:2] port, [1:0] reversed queue
   function automatic logic [3:0] split_slot(input logic [7:0] idx);
      logic [7:0] diff;
      // slot is used only after split_hit, so a wrapped difference is never used
      diff = idx - `IDX_PORT1_QUEUE3_SPLIT;
      split_slot = diff[3:0];
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // state
   // only the select bits, the global bit and the two-queue bits are
   // real storage; the low seven bits of each split register are
   // constants and cost no flops
   // the resolved mode and weights are registered again so that every
   // output of the block leaves a flop, at the price of one edge of lag

   logic [2:0][3:0] sel_reg; // select bits, [port][queue]
   logic [2:0][3:0] sel_next;
   logic global_strict_reg; // shared global control bit
   logic global_strict_next;
   logic [2:0] two_queue_reg; // per-port two-queue configuration
   logic [2:0] two_queue_next;
   logic pready_reg; // second access cycle marker
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   egress_queue_sched_pkg::sched_mode_e mode_reg [3]; // registered discipline
   egress_queue_sched_pkg::sched_mode_e mode_next [3];
   logic [3:0][6:0] weight_reg [3]; // registered weights
   logic [3:0][6:0] weight_next [3];

   logic [7:0] idx; // register index from the word address
   logic addr_ok; // aligned and inside the index space
   logic [3:0] slot;
   logic [1:0] slot_port;
   logic [1:0] slot_queue;
   logic access_first; // first access cycle, answer is prepared
   logic access_done; // completing edge, write takes effect

   //////////////////////////////////////////////////////////////////////////
   // address split, shared by read and write paths
   // index bits above the word space or byte offsets inside a word are
   // not mapped and are answered with an error further down
   // access_first and access_done split the access phase in two: the
   // first cycle prepares the answer, the second completes the transfer
   always_comb begin
      idx = paddr[9:2];
      addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
      slot = split_slot(idx);
      slot_port = slot[3:2];
      slot_queue = 2'h3 - slot[1:0]; // lowest index holds queue 3
      access_first = psel && penable && !pready_reg;
      access_done = psel && penable && pready_reg;
   end

   //////////////////////////////////////////////////////////////////////////
   // one wait state keeps every bus output straight from a flop
   // the read word is built one cycle early from the current state and
   // held in prdata_reg for the single cycle in which pready stands
   // hazard: a write that lands on the edge before the read is already
   // visible, since the read word is built after that edge
   // unused bits of every word read back as zero
   always_comb begin
      pready_next = access_first;
      pslverr_next = 1'b0;
      prdata_next = 32'h0;
      if (access_first) begin
         if (!addr_ok) begin
            pslverr_next = 1'b1; // unmapped, reads as zero
         end else if (split_hit(idx)) begin
            // bits 6:0 are constants, not storage
            prdata_next[`SPLIT_SEL_BIT] = sel_reg[slot_port][slot_queue]; // R6
            prdata_next[6:0] = egress_queue_sched_pkg::fixed_weight(slot_queue); // R4
         end else if (idx == `IDX_GLOBAL_CTRL) begin
            // only the strict-blocking bit exists, the rest reads zero
            prdata_next[`GLOBAL_STRICT_BIT] = global_strict_reg;
         end else if (idx == `IDX_QUEUE_COUNT) begin
            // bit 0 is port 1, bit 2 is port 3
            prdata_next[2:0] = two_queue_reg;
         end else if (idx == `IDX_MODE_STATUS) begin
            // live resolved discipline, two bits per port
            for (int p = 0; p < 3; p++) begin
               prdata_next[p*`MODE_FIELD_W +: `MODE_FIELD_W] = mode_reg[p];
            end
         end else begin
            // inside the word space but not a register
            pslverr_next = 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // register writes; only lane 0 carries data, upper lanes ignored
   // a write lands only at the completing edge, so a transfer cut short
   // by the master before pready leaves the registers untouched
   // unmapped or misaligned writes are dropped here and flagged by the
   // read path, which raises pslverr for the same transfer
   // limitation: the lane 0 strobe gates the whole word, the lanes above
   // it have nothing to hold
   always_comb begin
      sel_next = sel_reg;
      global_strict_next = global_strict_reg;
      two_queue_next = two_queue_reg;
      if (access_done && pwrite && addr_ok && pstrb[0]) begin
         if (split_hit(idx)) begin
            // only the select bit is stored; writes to 6:0 are dropped
            sel_next[slot_port][slot_queue] = pwdata[`SPLIT_SEL_BIT]; // R4 R6
         end else if (idx == `IDX_GLOBAL_CTRL) begin
            // a set bit keeps every port out of strict order
            global_strict_next = pwdata[`GLOBAL_STRICT_BIT];
         end else if (idx == `IDX_QUEUE_COUNT) begin
            // upper bits of the byte have no storage
            two_queue_next = pwdata[2:0];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // one resolver per port, each sees only its own group
   // the global bit is the one signal shared by all three resolvers;
   // a port never sees another port's select bits, so a write into one
   // group cannot change the discipline of another port
   egress_queue_sched_pkg::sched_mode_e mode_w [3];
   logic [3:0][6:0] weight_w [3];

   for (genvar p = 0; p < 3; p++) begin : g_port
      sched_cfg_if cfg_bus ();
      assign cfg_bus.sel = sel_reg[p]; // R5
      assign cfg_bus.global_bit = global_strict_reg;
      assign cfg_bus.two_queue = two_queue_reg[p];
      port_sched_mode u_mode (
         .cfg(cfg_bus.resolver)
      );
      assign mode_w[p] = cfg_bus.mode;
      assign weight_w[p] = cfg_bus.weight;
   end

   // outputs follow the resolver one edge later
   // a new select value reaches the egress scheduler one edge after it
   // is stored, and applies to every decision from then on
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         mode_next[p] = mode_w[p]; // R6
         weight_next[p] = weight_w[p];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // registers; select bits start at weighted
   // reset puts every port on 8:4:2:1 sharing, which matches what the
   // resolver makes of the reset select bits, so the outputs do not
   // jump when reset is released
   // the bus answer flops clear too, so no stale pready survives reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reg <= {12{`SPLIT_SEL_RESET}}; // R2
         global_strict_reg <= `GLOBAL_STRICT_RESET;
         two_queue_reg <= `QUEUE_COUNT_RESET;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
         // resolved copies start as the resolver would see them
         for (int p = 0; p < 3; p++) begin
            mode_reg[p] <= egress_queue_sched_pkg::weighted_four;
            weight_reg[p] <= {`WEIGHT_QUEUE3, `WEIGHT_QUEUE2, `WEIGHT_QUEUE1, `WEIGHT_QUEUE0};
         end
      end else begin
         sel_reg <= sel_next;
         global_strict_reg <= global_strict_next;
         two_queue_reg <= two_queue_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
         for (int p = 0; p < 3; p++) begin
            mode_reg[p] <= mode_next[p];
            weight_reg[p] <= weight_next[p];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // port drive
   // outputs are plain wires from the flops above; no logic sits between
   // a flop and a pin
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   for (genvar p = 0; p < 3; p++) begin : g_out
      assign egress_queue_mode[p] = mode_reg[p];
      assign egress_queue_weight[p] = weight_reg[p];
   end
endmodule // egress_queue_sched_select
`default_nettype wire

// ==== src/egress_queue_sched_defines.svh ====
// Behaviour
// R1: strict order only when all selects and global 0
// R2: select bits set (reset) give 8:4:2:1 weights
// R3: weighted with two queues gives 2:1 split
// R4: bits 6:0 read-only, fixed 8,4,2,1 defaults
// R5: select bits grouped and evaluated per port only
// R6: select bits writable anytime, apply to later decisions
`ifndef EGRESS_QUEUE_SCHED_DEFINES_SVH
`define EGRESS_QUEUE_SCHED_DEFINES_SVH

// register indices, byte address is four times the index
`define IDX_PORT1_QUEUE3_SPLIT 8'haf
`define IDX_PORT1_QUEUE2_SPLIT 8'hb0
`define IDX_PORT1_QUEUE1_SPLIT 8'hb1
`define IDX_PORT1_QUEUE0_SPLIT 8'hb2
`define IDX_PORT2_QUEUE3_SPLIT 8'hb3
`define IDX_PORT2_QUEUE2_SPLIT 8'hb4
`define IDX_PORT2_QUEUE1_SPLIT 8'hb5
`define IDX_PORT2_QUEUE0_SPLIT 8'hb6
`define IDX_PORT3_QUEUE3_SPLIT 8'hb7
`define IDX_PORT3_QUEUE2_SPLIT 8'hb8
`define IDX_PORT3_QUEUE1_SPLIT 8'hb9
`define IDX_PORT3_QUEUE0_SPLIT 8'hba
`define IDX_GLOBAL_CTRL 8'h05
`define IDX_QUEUE_COUNT 8'hf0
`define IDX_MODE_STATUS 8'hf1

// field positions
`define SPLIT_SEL_BIT 7
`define GLOBAL_STRICT_BIT 3
`define MODE_FIELD_W 2

// reset values
`define SPLIT_SEL_RESET 1'b1
`define GLOBAL_STRICT_RESET 1'b0
`define QUEUE_COUNT_RESET 3'h0

// fixed weights, queue 3 down to queue 0
`define WEIGHT_QUEUE3 7'h08
`define WEIGHT_QUEUE2 7'h04
`define WEIGHT_QUEUE1 7'h02
`define WEIGHT_QUEUE0 7'h01
// two-queue weights, upper and lower queue
`define WEIGHT_TWO_HIGH 7'h02
`define WEIGHT_TWO_LOW 7'h01
`define WEIGHT_NONE 7'h00

`endif

// ==== src/egress_queue_sched_pkg.sv ====
`include "egress_queue_sched_defines.svh"
package egress_queue_sched_pkg;
   // resolved scheduling discipline of one egress port
   typedef enum logic [1:0] {strict_order, weighted_four, weighted_two} sched_mode_e;
   typedef logic [6:0] weight_t;

   // fixed read-only weight of a queue
   function automatic weight_t fixed_weight(input logic [1:0] queue);
      case (queue)
         2'h3: fixed_weight = `WEIGHT_QUEUE3;
         2'h2: fixed_weight = `WEIGHT_QUEUE2;
         2'h1: fixed_weight = `WEIGHT_QUEUE1;
         default: fixed_weight = `WEIGHT_QUEUE0;
      endcase
   endfunction
endpackage

// ==== src/sched_cfg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// per-port bundle between the register bank and its resolver
interface sched_cfg_if;
   logic [3:0] sel; // select bits, index is queue
   logic global_bit; // shared global control bit
   logic two_queue; // port runs two queues
   egress_queue_sched_pkg::sched_mode_e mode; // resolved discipline
   logic [3:0][6:0] weight; // resolved weight per queue
   modport source (output sel, output global_bit, output two_queue, input mode, input weight);
   modport resolver (input sel, input global_bit, input two_queue, output mode, output weight);
endinterface
`default_nettype wire

// ==== src/port_sched_mode.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_sched_mode (
   sched_cfg_if.resolver cfg
);
   //////////////////////////////////////////////////////////////////////////
   // discipline of one port; sees only its own group of select bits
   always_comb begin
      if ((cfg.sel == 4'h0) && !cfg.global_bit) begin
         cfg.mode = egress_queue_sched_pkg::strict_order; // R1 R5
      end else if (cfg.two_queue) begin
         cfg.mode = egress_queue_sched_pkg::weighted_two; // R3
      end else begin
         // mixed select bits are not strict, so they fall to weighted
         cfg.mode = egress_queue_sched_pkg::weighted_four; // R2
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // weights handed to the egress scheduler
   always_comb begin
      for (int q = 0; q < 4; q++) begin
         case (cfg.mode)
            egress_queue_sched_pkg::weighted_four: begin
               cfg.weight[q] = egress_queue_sched_pkg::fixed_weight(2'(q)); // R2 R4
            end
            egress_queue_sched_pkg::weighted_two: begin
               // two-queue ports use queues 1 and 0
               if (q == 1) begin
                  cfg.weight[q] = `WEIGHT_TWO_HIGH; // R3
               end else if (q == 0) begin
                  cfg.weight[q] = `WEIGHT_TWO_LOW; // R3
               end else begin
                  cfg.weight[q] = `WEIGHT_NONE;
               end
            end
            default: begin
               cfg.weight[q] = `WEIGHT_NONE; // strict order has no weights
            end
         endcase
      end
   end
endmodule // port_sched_mode
`default_nettype wire

// ==== tb/egress_queue_sched_select_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module egress_queue_sched_select_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input var egress_queue_sched_pkg::sched_mode_e egress_queue_mode [3],
   input wire logic [3:0][6:0] egress_queue_weight [3]
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   logic done; // completing access phase
   logic wr_ok; // write that lands
   logic split; // address is a queue-split register
   logic [7:0] idx; // word index
   logic [1:0] prt; // port of a split register, 0 is port 1
   assign idx = paddr[9:2];
   assign done = psel && penable && pready && !pslverr;
   assign wr_ok = done && pwrite && pstrb[0];
   assign split = idx >= 8'haf && idx <= 8'hba;
   assign prt = 2'((idx - 8'haf) >> 2);
   ////////////////////////////////////////////////////////////////////////
   // strict order carries no weights
   a_strict_weights: assert property (
      egress_queue_mode[0] == egress_queue_sched_pkg::strict_order
      |-> egress_queue_weight[0] == 28'h0) else $error("strict port shows weights");
   // global bit set forbids strict on every port
   a_global_blocks: assert property (
      wr_ok && idx == 8'h05 && pwdata[3] |-> ##2
      egress_queue_mode[0] != egress_queue_sched_pkg::strict_order &&
      egress_queue_mode[1] != egress_queue_sched_pkg::strict_order &&
      egress_queue_mode[2] != egress_queue_sched_pkg::strict_order) else $error("strict kept");
   a_four_weights: assert property (
      egress_queue_mode[1] == egress_queue_sched_pkg::weighted_four
      |-> egress_queue_weight[1] == {7'h08, 7'h04, 7'h02, 7'h01}) else $error("bad 8421");
   a_two_weights: assert property (
      egress_queue_mode[1] == egress_queue_sched_pkg::weighted_two
      |-> egress_queue_weight[1] == {14'h0, 7'h02, 7'h01}) else $error("bad 2:1");
   // low bits read back fixed whatever was written
   a_fixed_low: assert property (
      done && !pwrite && split |-> prdata[6:0] == (7'h08 >> 2'(idx - 8'haf)))
      else $error("split low bits moved");
   // a port 2 write leaves the other ports alone
   a_port_group: assert property (
      wr_ok && split && prt == 2'h1 |-> ##2
      egress_queue_mode[0] == $past(egress_queue_mode[0], 2) &&
      egress_queue_mode[2] == $past(egress_queue_mode[2], 2)) else $error("group leak");
   a_status_mirror: assert property (
      done && !pwrite && idx == 8'hf1 |-> prdata[5:0] ==
      {egress_queue_mode[2], egress_queue_mode[1], egress_queue_mode[0]})
      else $error("status mismatch");
   // a set select bit ends strict one edge after the store; port taken at the store
   a_select_takes: assert property (
      wr_ok && split && pwdata[7] |-> ##2
      egress_queue_mode[$past(prt, 2)] != egress_queue_sched_pkg::strict_order)
      else $error("late");
   c_strict: cover property (egress_queue_mode[0] == egress_queue_sched_pkg::strict_order);
   c_port2_write: cover property (wr_ok && split && prt == 2'h1);
   c_two: cover property (egress_queue_mode[1] == egress_queue_sched_pkg::weighted_two);
   c_err: cover property (psel && penable && pready && pslverr);
endmodule // egress_queue_sched_select_asserts
bind egress_queue_sched_select egress_queue_sched_select_asserts chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
   .egress_queue_mode, .egress_queue_weight);
`default_nettype wire

// ==== tb/egress_queue_sched_select_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module egress_queue_sched_select_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, got;
   logic [3:0] pstrb;
   egress_queue_sched_pkg::sched_mode_e egress_queue_mode [3];
   logic [3:0][6:0] egress_queue_weight [3];
   int miscompares, comparisons;
   localparam logic [27:0] w4 = {7'h08, 7'h04, 7'h02, 7'h01}; // four-queue weights
   localparam logic [27:0] w2 = {14'h0, 7'h02, 7'h01}; // two-queue weights
   egress_queue_sched_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .egress_queue_mode, .egress_queue_weight);
   ////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // one apb transfer; wait is cut only by the watchdog
   task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, i, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      got = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // outputs settle one edge after the store
   task automatic port(input int p, input egress_queue_sched_pkg::sched_mode_e m,
      input logic [27:0] w);
      repeat (2) @(posedge pclk);
      chk({30'h0, egress_queue_mode[p]}, {30'h0, m});
      chk({4'h0, egress_queue_weight[p]}, {4'h0, w});
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      miscompares++;
      summarize;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         apb(1'b0, 8'(8'haf + i), 8'h00);
         chk(got, {24'h0, 1'b1, 7'h08 >> (i % 4)});
      end
      for (int p = 0; p < 3; p++) port(p, egress_queue_sched_pkg::weighted_four, w4);
      // clear port 1 selects, trying to overwrite the fixed bits too
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'(8'haf + i), 8'h7f);
         apb(1'b0, 8'(8'haf + i), 8'h00);
         chk(got, {25'h0, 7'h08 >> i});
         if (i == 2) port(0, egress_queue_sched_pkg::weighted_four, w4);
      end
      port(0, egress_queue_sched_pkg::strict_order, 28'h0);
      port(1, egress_queue_sched_pkg::weighted_four, w4);
      apb(1'b1, 8'h05, 8'h08);
      port(0, egress_queue_sched_pkg::weighted_four, w4);
      apb(1'b1, 8'h05, 8'h00);
      port(0, egress_queue_sched_pkg::strict_order, 28'h0);
      for (int i = 0; i < 4; i++) apb(1'b1, 8'(8'hb7 + i), 8'h00);
      port(2, egress_queue_sched_pkg::strict_order, 28'h0);
      port(1, egress_queue_sched_pkg::weighted_four, w4);
      apb(1'b1, 8'hf0, 8'h07);
      port(1, egress_queue_sched_pkg::weighted_two, w2);
      port(0, egress_queue_sched_pkg::strict_order, 28'h0);
      apb(1'b0, 8'hf1, 8'h00);
      chk(got, 32'h08);
      apb(1'b1, 8'hb2, 8'h80);
      port(0, egress_queue_sched_pkg::weighted_two, w2);
      // clear port 2 selects; only its own discipline may move
      for (int i = 0; i < 4; i++) apb(1'b1, 8'(8'hb3 + i), 8'h00);
      port(1, egress_queue_sched_pkg::strict_order, 28'h0);
      port(0, egress_queue_sched_pkg::weighted_two, w2);
      apb(1'b0, 8'hf1, 8'h00);
      chk(got, 32'h02);
      // unmapped word answers with an error
      apb(1'b0, 8'h10, 8'h00);
      chk({got[31:1], err}, 32'h1);
      summarize;
   end
endmodule // egress_queue_sched_select_tb_top
`default_nettype wire
